// >>> shared/qrvf_pkg.sv
package qrvf_pkg;

   localparam int CLK_MHZ = 40;
   localparam int CLK_HZ = 40_000_000;

   // Valley time-out, stands in for a missing valley
   localparam int TMO_NS = 6500;
   localparam int TMO_CYC = TMO_NS * CLK_MHZ / 1000;
   // Auxiliary-short timer
   localparam int AUX_MS = 90;
   localparam int AUX_CYC = AUX_MS * (CLK_HZ / 1000);
   // Auto-recovery interval
   localparam int RECOV_S = 4;
   localparam int RECOV_CYC = RECOV_S * CLK_HZ;
   // Low-line blanking
   localparam int LL_MS = 25;
   localparam int LL_CYC = LL_MS * (CLK_HZ / 1000);
   // Leading-edge blanking, short comparator much faster than limit comparator
   localparam int LIMIT_BLANK_NS = 350;
   localparam int LIMIT_BLANK_CYC = (LIMIT_BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int SHORT_BLANK_NS = 100;
   localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS * CLK_MHZ + 999) / 1000;
   // Longest on-time
   localparam int MAX_ON_NS = 36000;
   localparam int MAX_ON_CYC = MAX_ON_NS * CLK_MHZ / 1000;
   localparam int WOD_PERIODS = 4;
   localparam int LOW_LINE_VALLEY = 1;
   localparam int HIGH_LINE_VALLEY = 2;

   // Dimming input digitised by a 10-bit converter over 0..2.5 V
   localparam int ADC_FS_MV = 2500;
   localparam int DIM_LOWER_MV = 700;
   localparam int DIM_UPPER_MV = 2450;
   localparam logic [9:0] DIM_LO_CODE = 10'(DIM_LOWER_MV * 1023 / ADC_FS_MV);
   localparam logic [9:0] DIM_HI_CODE = 10'(DIM_UPPER_MV * 1023 / ADC_FS_MV);
   localparam logic [9:0] DIM_SPAN = DIM_HI_CODE - DIM_LO_CODE;
   localparam logic [8:0] REF_FULL = 9'h100;

   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CREF = 4'h8;
   localparam logic [3:0] REG_VALLEY = 4'hC;

   typedef struct packed {
      logic [3:0] vsel;
      logic [1:0] rsv;
      logic latch_mode;
      logic enable;
   } qrvf_ctrl_t;

   localparam qrvf_ctrl_t CTRL_RST = '{vsel: 4'h3, rsv: 2'h0, latch_mode: 1'b0, enable: 1'b1};

   typedef struct packed {
      logic valley_below;
      logic aux_above;
      logic line_below_ll;
      logic line_above_hl;
      logic cs_above_ref;
      logic cs_above_limit;
      logic cs_above_short;
      logic vcc_ovp;
      logic sd_ovp;
      logic vcc_on;
      logic dim_open;
      logic foldback_active;
   } qrvf_sense_t;

   typedef enum logic [1:0] {
      GS_WAIT = 2'b00,
      GS_ON = 2'b01,
      GS_DEMAG = 2'b10
   } qrvf_gate_state_t;

   typedef enum logic [1:0] {
      FS_RUN = 2'b00,
      FS_RECOVER = 2'b01,
      FS_WAIT_VCC = 2'b10,
      FS_LATCH = 2'b11
   } qrvf_fault_state_t;

   typedef enum logic [2:0] {
      FC_NONE = 3'b000,
      FC_AUX = 3'b001,
      FC_WOD = 3'b010,
      FC_VCC_OVP = 3'b011,
      FC_SD_OVP = 3'b100
   } qrvf_cause_t;

   typedef struct packed {
      qrvf_ctrl_t ctrl;
      logic bus_wait;
      logic [31:0] rdata;
      logic vb_q;
      logic vclk;
      logic tmo_pulse;
      logic [8:0] tmo_cnt;
      logic high_line;
      logic [19:0] ll_cnt;
      logic [21:0] aux_cnt;
      logic aux_fault;
      logic [27:0] rec_cnt;
      qrvf_gate_state_t gstate;
      qrvf_fault_state_t fstate;
      qrvf_cause_t cause;
      logic fault_active;
      logic gate;
      logic [3:0] vcnt;
      logic [10:0] on_cnt;
      logic [3:0] leb_cnt;
      logic [2:0] sleb_cnt;
      logic wod_seen;
      logic [2:0] wod_cnt;
      logic [8:0] cref;
   } qrvf_state_t;

endpackage

// >>> logic/qrvf_core.sv
// What this block does
// - A falling crossing of valley sense below its threshold is a valley event.
// - Valley sense held below threshold for 6.5 us produces a time-out pulse.
// - Time-out pulses act as substitute valley clocks for missed valleys.
// - Aux-short timer restarts on rise above 1 V and is held cleared during a fault; 90 ms raises fault.
// - Aux-short fault halts drive for 4 s, or latches off in latching variant.
// - Full load: start on first valley clock at low line, second at high.
// - In thermal foldback wait a selected number of valley clocks per pulse.
// - Low line declared only after line sense stays low for 25 ms.
// - High line declared at once when line sense exceeds its threshold.
// - Reference zero below lower dim level, full above upper, linear between.
// - Gate drive disabled while dimming input sits below lower level.
// - Dimming and foldback reductions multiply into the effective reference.
// - Open dimming input reads as full setpoint.
// - Peak-limit comparator ends the drive pulse at once.
// - Winding-short blanking much shorter than limit blanking.
// - Four consecutive periods above 150 % limit trip recovery or latch.
// - Supply overvoltage stops drive and enters auto-recovery in all variants.
// - Shutdown-sense overvoltage latches or auto-recovers per variant.
// - After a latching fault drive stays off until supply reset.
// - After recovery interval, resume only once supply passed turn-on.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module qrvf_core #(
   parameter int AUX_CYC_P = qrvf_pkg::AUX_CYC,
   parameter int RECOV_CYC_P = qrvf_pkg::RECOV_CYC,
   parameter int LL_CYC_P = qrvf_pkg::LL_CYC
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire qrvf_pkg::qrvf_sense_t sense_i,
   input wire logic [9:0] dim_code_i,
   input wire logic [8:0] fold_factor_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic gate_o,
   output logic [8:0] current_reference_o,
   output logic aux_short_fault_o,
   output logic fault_active_o,
   output logic high_line_o
);
   import qrvf_pkg::*;

   qrvf_state_t s;
   qrvf_state_t n;

   function automatic logic [8:0] qrvf_dim_frac(input logic [9:0] code, input logic open_in);
      logic [17:0] num;
      logic [8:0] frac;
      num = {8'h00, code - DIM_LO_CODE} << 8;
      if (open_in || code >= DIM_HI_CODE) begin
         frac = REF_FULL;
      end else if (code <= DIM_LO_CODE) begin
         frac = 9'h000;
      end else begin
         frac = 9'(num / 18'(DIM_SPAN));
      end
      return frac;
   endfunction

   function automatic logic [31:0] qrvf_reg_read(input qrvf_state_t st, input logic [3:0] addr);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (addr)
         REG_CTRL: d = {24'h00_0000, st.ctrl};
         REG_STATUS: d = {20'h0_0000, st.wod_cnt, st.cause, st.fstate, st.aux_fault, st.fault_active,
                          st.high_line, st.gate};
         REG_CREF: d = {23'h00_0000, st.cref};
         REG_VALLEY: d = {26'h000_0000, st.gstate, st.vcnt};
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   logic valley_evt;
   logic tmo_hit;
   logic aux_trip;
   logic wod_trip;
   logic dim_on;
   logic run_ok;
   logic end_pulse;
   logic short_now;
   logic [3:0] need;
   logic [8:0] dim_frac;
   logic [8:0] fold;
   logic [17:0] prod;
   logic [2:0] wod_next;

   always_comb begin
      n = s;
      valley_evt = 1'b0;
      tmo_hit = 1'b0;
      aux_trip = 1'b0;
      wod_trip = 1'b0;
      end_pulse = 1'b0;
      short_now = 1'b0;
      wod_next = 3'h0;

      // Valley clock: a detected valley or a time-out, registered to one pulse
      n.vb_q = sense_i.valley_below;
      valley_evt = sense_i.valley_below && !s.vb_q;
      if (!sense_i.valley_below) begin
         n.tmo_cnt = 9'h000;
      end else if (s.tmo_cnt == 9'(TMO_CYC - 1)) begin
         n.tmo_cnt = 9'h000;
         tmo_hit = 1'b1;
      end else begin
         n.tmo_cnt = s.tmo_cnt + 9'h001;
      end
      n.tmo_pulse = tmo_hit;
      n.vclk = valley_evt || tmo_hit;

      // Line range
      if (sense_i.line_above_hl) begin
         n.high_line = 1'b1;
         n.ll_cnt = 20'h0_0000;
      end else if (sense_i.line_below_ll) begin
         if (s.ll_cnt == 20'(LL_CYC_P - 1)) begin
            n.high_line = 1'b0;
         end else begin
            n.ll_cnt = s.ll_cnt + 20'h0_0001;
         end
      end else begin
         n.ll_cnt = 20'h0_0000;
      end

      // Current reference
      dim_frac = qrvf_dim_frac(dim_code_i, sense_i.dim_open);
      fold = sense_i.foldback_active ? fold_factor_i : REF_FULL;
      prod = 18'(dim_frac) * 18'(fold);
      n.cref = prod[16:8];
      dim_on = sense_i.dim_open || dim_code_i > DIM_LO_CODE;

      // Aux-short timer, held cleared while the block is already in a fault
      if (sense_i.aux_above || s.fstate != FS_RUN) begin
         n.aux_cnt = 22'h00_0000;
      end else if (s.aux_cnt == 22'(AUX_CYC_P - 1)) begin
         n.aux_cnt = 22'h00_0000;
         aux_trip = 1'b1;
      end else begin
         n.aux_cnt = s.aux_cnt + 22'h00_0001;
      end

      // Gate drive sequencing
      run_ok = s.fstate == FS_RUN && s.ctrl.enable && dim_on;
      if (sense_i.foldback_active) begin
         need = (s.ctrl.vsel == 4'h0) ? 4'h1 : s.ctrl.vsel;
      end else begin
         need = s.high_line ? 4'(HIGH_LINE_VALLEY) : 4'(LOW_LINE_VALLEY);
      end
      case (s.gstate)
         GS_WAIT: begin
            if (!run_ok) begin
               n.vcnt = 4'h0;
            end else if (s.vclk) begin
               if (s.vcnt + 4'h1 >= need) begin
                  n.vcnt = 4'h0;
                  n.gate = 1'b1;
                  n.gstate = GS_ON;
                  n.on_cnt = 11'h000;
                  n.leb_cnt = 4'(LIMIT_BLANK_CYC);
                  n.sleb_cnt = 3'(SHORT_BLANK_CYC);
                  n.wod_seen = 1'b0;
               end else begin
                  n.vcnt = s.vcnt + 4'h1;
               end
            end
         end
         GS_ON: begin
            n.on_cnt = s.on_cnt + 11'h001;
            if (s.leb_cnt != 4'h0) begin
               n.leb_cnt = s.leb_cnt - 4'h1;
            end
            if (s.sleb_cnt != 3'h0) begin
               n.sleb_cnt = s.sleb_cnt - 3'h1;
            end
            short_now = s.sleb_cnt == 3'h0 && sense_i.cs_above_short;
            n.wod_seen = s.wod_seen || short_now;
            end_pulse = !run_ok || s.on_cnt == 11'(MAX_ON_CYC - 1) ||
                        (s.leb_cnt == 4'h0 && (sense_i.cs_above_limit || sense_i.cs_above_ref));
            if (end_pulse) begin
               n.gate = 1'b0;
               n.gstate = GS_DEMAG;
               wod_next = (s.wod_seen || short_now) ? s.wod_cnt + 3'h1 : 3'h0;
               n.wod_cnt = wod_next;
               wod_trip = wod_next == 3'(WOD_PERIODS);
            end
         end
         GS_DEMAG: begin
            // A shorted aux winding never lifts valley sense; time-out still moves on
            if (!sense_i.valley_below || s.tmo_pulse) begin
               n.gstate = GS_WAIT;
               n.vcnt = 4'h0;
            end
         end
         default: begin
            n.gstate = GS_WAIT;
            n.gate = 1'b0;
         end
      endcase

      // Fault handling
      case (s.fstate)
         FS_RUN: begin
            if (s.ctrl.latch_mode && (aux_trip || wod_trip || sense_i.sd_ovp)) begin
               n.fstate = FS_LATCH;
            end else if (aux_trip || wod_trip || sense_i.sd_ovp || sense_i.vcc_ovp) begin
               n.fstate = FS_RECOVER;
               n.rec_cnt = 28'h000_0000;
            end
            if (sense_i.vcc_ovp) begin
               n.cause = FC_VCC_OVP;
            end else if (sense_i.sd_ovp) begin
               n.cause = FC_SD_OVP;
            end else if (wod_trip) begin
               n.cause = FC_WOD;
            end else if (aux_trip) begin
               n.cause = FC_AUX;
            end
            if (aux_trip) begin
               n.aux_fault = 1'b1;
            end
         end
         FS_RECOVER: begin
            if (s.rec_cnt == 28'(RECOV_CYC_P - 1)) begin
               n.fstate = FS_WAIT_VCC;
            end else begin
               n.rec_cnt = s.rec_cnt + 28'h000_0001;
            end
         end
         FS_WAIT_VCC: begin
            if (sense_i.vcc_on) begin
               n.fstate = FS_RUN;
               n.aux_fault = 1'b0;
               n.cause = FC_NONE;
            end
         end
         FS_LATCH: n.fstate = FS_LATCH;
         default: n.fstate = FS_RUN;
      endcase
      if (n.fstate != FS_RUN) begin
         n.wod_cnt = 3'h0;
      end
      n.fault_active = n.fstate != FS_RUN;

      // Avalon slave: one wait state, then the access completes
      if (s.bus_wait) begin
         if (avs_read_i || avs_write_i) begin
            n.bus_wait = 1'b0;
            n.rdata = avs_read_i ? qrvf_reg_read(s, avs_address_i) : 32'h0000_0000;
         end
      end else begin
         n.bus_wait = 1'b1;
         if (avs_write_i && avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
            n.ctrl = avs_writedata_i[7:0];
            n.ctrl.rsv = 2'h0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s <= '0;
         s.bus_wait <= 1'b1;
         s.ctrl <= CTRL_RST;
      end else begin
         s <= n;
      end
   end

   assign avs_readdata_o = s.rdata;
   assign avs_waitrequest_o = s.bus_wait;
   assign gate_o = s.gate;
   assign current_reference_o = s.cref;
   assign aux_short_fault_o = s.aux_fault;
   assign fault_active_o = s.fault_active;
   assign high_line_o = s.high_line;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   AST_VALLEY_EVENT: assert property (sense_i.valley_below && !s.vb_q |=> s.vclk)
      else $error("valley crossing did not give a valley clock");

   AST_TIMEOUT_PULSE: assert property ($rose(sense_i.valley_below) ##1 sense_i.valley_below [*8]
      |-> !s.tmo_pulse)
      else $error("time-out pulse came too early");

   AST_TIMEOUT_CLOCK: assert property (s.tmo_pulse |-> s.vclk)
      else $error("time-out pulse not used as valley clock");

   AST_AUX_TRIP: assert property (s.fstate == FS_RUN && !sense_i.aux_above &&
      s.aux_cnt == 22'(AUX_CYC_P - 1) |=> s.aux_fault && s.fstate != FS_RUN)
      else $error("aux-short timer expiry did not raise the fault");

   AST_NO_DRIVE_IN_FAULT: assert property (s.fault_active |=> !s.gate)
      else $error("drive pulse while a fault holds");

   AST_PEAK_LIMIT: assert property (s.gate && s.leb_cnt == 4'h0 && sense_i.cs_above_limit
      |=> !s.gate ##1 !s.gate)
      else $error("peak limit did not end the pulse");

   AST_HIGH_LINE: assert property (sense_i.line_above_hl |=> s.high_line)
      else $error("high line not declared at once");

   AST_LOW_LINE_BLANK: assert property (s.high_line && !sense_i.line_below_ll |=> s.high_line)
      else $error("low line declared without blanking");

   AST_DIM_OFF: assert property (!sense_i.dim_open && dim_code_i <= DIM_LO_CODE && s.gstate == GS_WAIT
      |=> !s.gate)
      else $error("drive started with dimming below lower level");

   AST_VCC_OVP: assert property (s.fstate == FS_RUN && sense_i.vcc_ovp |=> s.fstate == FS_RECOVER)
      else $error("supply overvoltage did not enter auto-recovery");

   AST_LATCH_HOLD: assert property (s.fstate == FS_LATCH |=> s.fstate == FS_LATCH && !s.gate)
      else $error("latched fault released without supply reset");

   AST_RESUME_VCC: assert property (s.fstate == FS_WAIT_VCC && !sense_i.vcc_on |=> s.fstate == FS_WAIT_VCC)
      else $error("resumed before supply turn-on");

   AST_WOD_CLEAR: assert property (s.gstate == GS_ON && !s.wod_seen && !sense_i.cs_above_short &&
      sense_i.cs_above_limit && s.leb_cnt == 4'h0 |=> s.wod_cnt == 3'h0)
      else $error("winding-short count kept after a clean period");

   AST_TIMEOUT_EXPIRY: assert property (sense_i.valley_below && s.tmo_cnt == 9'(TMO_CYC - 1) |=> s.tmo_pulse)
      else $error("time-out pulse missing after full low period");

   // First clock at low line starts the pulse straight away
   AST_LOW_LINE_START: assert property (!sense_i.foldback_active && !s.high_line && s.gstate == GS_WAIT &&
      run_ok && s.vclk && s.vcnt == 4'h0 |=> s.gate)
      else $error("low line did not start on first valley clock");

   AST_HIGH_LINE_SKIP: assert property (!sense_i.foldback_active && s.high_line && s.gstate == GS_WAIT &&
      run_ok && s.vclk && s.vcnt == 4'h0 |=> !s.gate && s.vcnt == 4'h1)
      else $error("high line did not skip the first valley");

   AST_FOLD_COUNT: assert property (sense_i.foldback_active && s.ctrl.vsel > 4'h1 && s.gstate == GS_WAIT &&
      run_ok && s.vclk && s.vcnt == 4'h0 |=> !s.gate)
      else $error("foldback started before the selected valley");

   AST_DIM_ZERO: assert property (!sense_i.dim_open && dim_code_i <= DIM_LO_CODE |=> s.cref == 9'h000)
      else $error("reference not zero below lower dim level");

   AST_DIM_OPEN_FULL: assert property (sense_i.dim_open && !sense_i.foldback_active |=> s.cref == REF_FULL)
      else $error("open dimming input did not give full reference");

   // With full dimming the product reduces to the foldback factor alone
   AST_FOLD_PRODUCT: assert property ((sense_i.dim_open || dim_code_i >= DIM_HI_CODE) && sense_i.foldback_active
      |=> s.cref == $past(fold_factor_i))
      else $error("foldback factor not applied to reference");

   AST_SHORT_BLANK: assert property (s.gstate == GS_ON && s.sleb_cnt == 3'h0 && s.leb_cnt != 4'h0 &&
      sense_i.cs_above_short |=> s.wod_seen)
      else $error("short overshoot missed inside limit blanking");

   AST_WOD_TRIP: assert property (s.fstate == FS_RUN && s.gstate == GS_ON && s.wod_seen && s.leb_cnt == 4'h0 &&
      s.wod_cnt == 3'(WOD_PERIODS - 1) && (sense_i.cs_above_limit || sense_i.cs_above_ref)
      |=> s.fstate != FS_RUN)
      else $error("fourth shorted period did not trip");

   AST_SD_OVP: assert property (s.fstate == FS_RUN && sense_i.sd_ovp
      |=> s.fstate == ($past(s.ctrl.latch_mode) ? FS_LATCH : FS_RECOVER))
      else $error("shutdown-sense overvoltage handled against variant");

   AST_LOW_LINE_RESTART: assert property (!sense_i.line_below_ll && !sense_i.line_above_hl
      |=> s.ll_cnt == 20'h0_0000)
      else $error("low-line blanking not restarted");

endmodule
`default_nettype wire

// >>> dv/qrvf_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module qrvf_stage_model #(
   parameter int REF_CYC = 16,
   parameter int LIM_CYC = 24,
   parameter int DEMAG_CYC = 8,
   parameter int RING_CYC = 4
) (
   input wire logic clk_i,
   input wire logic gate_i,
   input wire logic [1:0] mode_i,
   input wire logic no_ref_i,
   output logic valley_below_o,
   output logic aux_above_o,
   output logic cs_above_ref_o,
   output logic cs_above_limit_o,
   output logic cs_above_short_o
);
   // Modes: 0 healthy, 1 shorted winding, 2 damped ringing, 3 aux winding shorted
   int on_cnt = 0;
   int off_cnt = 0;
   always_ff @(posedge clk_i) begin
      on_cnt <= gate_i ? on_cnt + 1 : 0;
      off_cnt <= gate_i ? 0 : off_cnt + 1;
   end
   assign cs_above_ref_o = gate_i && !no_ref_i && on_cnt >= REF_CYC;
   assign cs_above_limit_o = gate_i && on_cnt >= LIM_CYC;
   // Overshoot only inside the limit blanking, so a long short blanking would miss it
   assign cs_above_short_o = gate_i && mode_i == 2'd1 && on_cnt >= 6 && on_cnt < 10;
   assign aux_above_o = !gate_i && off_cnt < DEMAG_CYC && mode_i != 2'd3;
   assign valley_below_o = mode_i == 2'd3 || (!gate_i && off_cnt >= DEMAG_CYC &&
      (mode_i == 2'd2 || (off_cnt - DEMAG_CYC) % RING_CYC < RING_CYC / 2));
endmodule
`default_nettype wire

// >>> dv/qrvf_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module qrvf_core_tb;
   import qrvf_pkg::*;
   localparam int AUX_P = 600;
   localparam int REC_P = 40;
   localparam int LL_P = 30;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0, wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] q, rdata;
   logic wait_o, gate, aux_f, fault, hl, vb, aux_a, cs_r, cs_l, cs_s;
   logic [8:0] cref;
   logic [1:0] mode = 2'h0;
   logic no_ref = 1'b0, ll = 1'b0, hlin = 1'b0, vovp = 1'b0, sovp = 1'b0;
   logic von = 1'b1, dopen = 1'b0, fold = 1'b0;
   logic [9:0] dimming_input = 10'h3FF;
   logic [8:0] ffac = 9'h100;
   logic [9:0] codes [5];
   qrvf_sense_t sense;
   int error_cnt = 0, n_checks = 0, n, p, e, em;
   int on_len = 0, last_on = 0, vcnt = 0, last_vc = 0, gap = 0, last_gap = 0, pulses = 0;
   logic vb_d = 1'b0, gate_d = 1'b0, fault_d = 1'b0;

   always #12.5 clk = ~clk;
   assign sense = '{vb, aux_a, ll, hlin, cs_r, cs_l, cs_s, vovp, sovp, von, dopen, fold};

   qrvf_core #(.AUX_CYC_P(AUX_P), .RECOV_CYC_P(REC_P), .LL_CYC_P(LL_P)) u_dut (
      .clk_i(clk), .arst_n_i(arst_n), .sense_i(sense), .dim_code_i(dimming_input), .fold_factor_i(ffac),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .gate_o(gate),
      .current_reference_o(cref), .aux_short_fault_o(aux_f), .fault_active_o(fault), .high_line_o(hl));

   qrvf_stage_model u_stage (.clk_i(clk), .gate_i(gate), .mode_i(mode), .no_ref_i(no_ref),
      .valley_below_o(vb), .aux_above_o(aux_a), .cs_above_ref_o(cs_r), .cs_above_limit_o(cs_l),
      .cs_above_short_o(cs_s));

   task automatic give_verdict();
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic fail(input string m);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask

   task automatic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi, input string m);
      n_checks++;
      if ((v >= lo && v <= hi) !== 1'b1) fail($sformatf("%s got %0d", m, v));
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Request held until waitrequest is sampled low; an idle edge follows before the next one
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
         k++;
      end while (wait_o !== 1'b0 && k < 50);
      if (k >= 50) begin
         fail("bus hang");
         give_verdict();
      end
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
      k = 0;
      while (s !== v && k < lim) begin
         @(posedge clk);
         k++;
      end
      if (k >= lim) begin
         fail("level wait");
         give_verdict();
      end
   endtask

   task automatic next_pulse();
      int k, c;
      c = pulses;
      k = 0;
      while (pulses == c && k < 2000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 2000) begin
         fail("no pulse");
         give_verdict();
      end
   endtask

   always @(posedge clk) begin
      vb_d <= vb;
      gate_d <= gate;
      fault_d <= fault;
      if (fault && fault_d && gate) fail("gate during fault");
      if (gate) begin
         on_len <= on_len + 1;
      end else begin
         on_len <= 0;
         gap <= gap + 1;
         if (vb && !vb_d) vcnt <= vcnt + 1;
      end
      if (gate && !gate_d) begin
         last_vc <= vcnt;
         last_gap <= gap;
         pulses <= pulses + 1;
         vcnt <= 0;
         gap <= 0;
      end
      if (!gate && gate_d) last_on <= on_len;
   end

   initial begin
      cyc(8);
      arst_n <= 1'b1;
      cyc(1);
      cmp(wait_o, 32'h1, "idle wait");
      cmp(hl, 32'h0, "line at reset");
      bus(1'b0, REG_CTRL, 32'h0, q);
      cmp(q, 32'h0000_0031, "ctrl reset");
      bus(1'b1, REG_CTRL, 32'h0000_00FF, q);
      bus(1'b0, REG_CTRL, 32'h0, q);
      cmp(q, 32'h0000_00F3, "ctrl rsv");
      bus(1'b0, 4'h2, 32'h0, q);
      cmp(q, 32'h0, "unmapped");
      bus(1'b1, REG_CTRL, 32'h0000_0031, q);
      codes = '{10'h000, DIM_LO_CODE, DIM_LO_CODE + DIM_SPAN / 2, DIM_HI_CODE + 10'h001, 10'h3FF};
      foreach (codes[i]) begin
         dimming_input <= codes[i];
         cyc(4);
         e = codes[i] <= DIM_LO_CODE ? 0 : codes[i] >= DIM_HI_CODE ? 256 :
             (int'(codes[i]) - int'(DIM_LO_CODE)) * 256 / int'(DIM_SPAN);
         in_range(cref, e > 0 ? e - 1 : 0, e, "dim ref");
      end
      em = (int'(DIM_SPAN) / 2) * 256 / int'(DIM_SPAN) * 128 / 256;
      dimming_input <= codes[2];
      fold <= 1'b1;
      ffac <= 9'h080;
      cyc(4);
      in_range(cref, em - 2, em, "fold ref");
      next_pulse();
      next_pulse();
      cmp(last_vc, 32'h3, "fold valleys");
      fold <= 1'b0;
      dimming_input <= DIM_LO_CODE;
      cyc(40);
      p = pulses;
      cyc(150);
      cmp(pulses - p, 32'h0, "pulse while dimmed");
      dopen <= 1'b1;
      cyc(4);
      cmp(cref, 32'h100, "open dim ref");
      next_pulse();
      dopen <= 1'b0;
      dimming_input <= 10'h3FF;
      next_pulse();
      next_pulse();
      cmp(last_vc, 32'h1, "low line valley");
      in_range(last_on, 16, 19, "ref end");
      no_ref <= 1'b1;
      next_pulse();
      next_pulse();
      in_range(last_on, 24, 27, "limit end");
      no_ref <= 1'b0;
      hlin <= 1'b1;
      cyc(1);
      hlin <= 1'b0;
      cyc(3);
      cmp(hl, 32'h1, "high line");
      next_pulse();
      next_pulse();
      cmp(last_vc, 32'h2, "high line valley");
      mode <= 2'h2;
      next_pulse();
      next_pulse();
      in_range(last_gap, 263, 278, "time-out gap");
      mode <= 2'h0;
      ll <= 1'b1;
      cyc(20);
      ll <= 1'b0;
      cyc(2);
      ll <= 1'b1;
      wait_lvl(hl, 1'b0, 100, n);
      in_range(n, LL_P - 2, LL_P + 3, "low line blanking");
      next_pulse();
      mode <= 2'h1;
      repeat (3) next_pulse();
      mode <= 2'h0;
      repeat (2) next_pulse();
      cmp(fault, 32'h0, "three shorts");
      mode <= 2'h1;
      repeat (3) next_pulse();
      cyc(20);
      mode <= 2'h0;
      wait_lvl(fault, 1'b1, 60, n);
      von <= 1'b0;
      bus(1'b0, REG_STATUS, 32'h0, q);
      cmp(q[8:4], 32'h0D - 32'h4, "winding cause");
      cyc(60);
      cmp(fault, 32'h1, "waits supply");
      von <= 1'b1;
      wait_lvl(fault, 1'b0, 10, n);
      bus(1'b1, REG_CTRL, 32'h0000_0033, q);
      mode <= 2'h3;
      wait_lvl(aux_f, 1'b1, AUX_P + 100, n);
      in_range(n, AUX_P - 40, AUX_P + 5, "aux timer");
      cyc(200);
      cmp(fault, 32'h1, "aux latched");
      bus(1'b0, REG_STATUS, 32'h0, q);
      cmp(q[5:4], 32'h3, "latched state");
      mode <= 2'h0;
      arst_n <= 1'b0;
      cyc(2);
      arst_n <= 1'b1;
      cyc(1);
      cmp({aux_f, fault}, 32'h0, "reset clears latch");
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, REG_CTRL, 32'h0000_0031 | 32'((k % 2) * 2), q);
         vovp <= k < 2;
         sovp <= k >= 2;
         cyc(2);
         vovp <= 1'b0;
         sovp <= 1'b0;
         wait_lvl(fault, 1'b1, 10, n);
         bus(1'b0, REG_STATUS, 32'h0, q);
         cmp(q[8:4], k == 3 ? 32'h13 : k < 2 ? 32'h0D : 32'h11, "ovp state");
         if (k == 3) begin
            cyc(200);
            cmp(fault, 32'h1, "sd latched");
         end else begin
            wait_lvl(fault, 1'b0, REC_P + 40, n);
            in_range(n, REC_P - 10, REC_P + 30, "recovery");
         end
      end
      give_verdict();
   end
endmodule
`default_nettype wire
